// File: logic/srelc_params.svh
// Offsets, field positions, reset values and timing counts of the load controller
`ifndef SRELC_PARAMS_SVH
`define SRELC_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define SRELC_CTRL 8'h00
`define SRELC_STATUS 8'h04
`define SRELC_MASK 8'h08
`define SRELC_INFO 8'h0c
`define SRELC_CFG_BASE 8'h20
// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define SRELC_CTRL_RELOAD 0
`define SRELC_CTRL_DEV_LSB 8
`define SRELC_DEV_RST 7'h50
`define SRELC_EE_OFFSET 8'h00
`define SRELC_EV_OK 0
`define SRELC_EV_FAIL 1
`define SRELC_EV_START 2
`define SRELC_ADDR_HI 3'h3
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SRELC_CLK_MHZ 250
`define SRELC_QTR_NS 2500
`define SRELC_QTR_CYC ((`SRELC_QTR_NS * `SRELC_CLK_MHZ + 999) / 1000)
`define SRELC_LOAD_BYTES 8
`define SRELC_SETTLE_CYC 4

`endif

// File: logic/srelc_pkg.sv
// Types shared by the load controller modules
package srelc_pkg;

    typedef enum logic [1:0] {
        LVL_LOW = 2'h0,
        LVL_WEAK = 2'h1,
        LVL_FLOAT = 2'h2,
        LVL_HIGH = 2'h3
    } srelc_lvl_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_START = 7'h02,
        ST_BIT = 7'h04,
        ST_ACK = 7'h08,
        ST_STOP = 7'h10,
        ST_OK = 7'h20,
        ST_FAIL = 7'h40
    } srelc_state_t;

endpackage : srelc_pkg

// File: logic/srelc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps

module srelc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : srelc_sync

// File: logic/srelc_strap.sv
// Captures the role and address straps once after reset release
`timescale 1ns/10ps
`include "srelc_params.svh"

module srelc_strap
    import srelc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] bus_role_select_lvl,
    input wire logic [3:0] bus_address_strap_lvl,
    output srelc_lvl_t role,
    output logic [6:0] tgt_addr,
    output logic valid
);

    logic [2:0] settle;

    // Waits for the synchroniser to fill, then freezes the levels for good
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            settle <= '0;
            valid <= 1'b0;
            role <= LVL_LOW;
            tgt_addr <= '0;
        end else if (!valid) begin
            settle <= settle + 3'd1;
            if (settle == 3'(`SRELC_SETTLE_CYC)) begin
                valid <= 1'b1;
                role <= srelc_lvl_t'(bus_role_select_lvl);
                tgt_addr <= {`SRELC_ADDR_HI, bus_address_strap_lvl};
            end
        end
    end

endmodule : srelc_strap

// File: logic/srelc_top.sv
// Bus role, address straps and EEPROM configuration load with register slave
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "srelc_params.svh"

module srelc_top
    import srelc_pkg::*;
#(
    parameter int QTR_CYC = `SRELC_QTR_CYC,
    parameter int LOAD_BYTES = `SRELC_LOAD_BYTES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic load_start_n,
    input wire logic [1:0] bus_role_select_lvl,
    input wire logic [3:0] bus_address_strap_lvl,
    input wire logic bus_clock_line_i,
    output logic bus_clock_line_o,
    output logic bus_clock_line_oe,
    input wire logic bus_data_line_i,
    output logic bus_data_line_o,
    output logic bus_data_line_oe,
    output logic done_n,
    output logic int_n_o,
    output logic int_n_oe
);

    // ---------------------------------------------------------------
    // Pin synchronisers and straps
    // ---------------------------------------------------------------
    logic [8:0] sync_q;
    logic ls_s;
    logic scl_s;
    logic sda_s;
    srelc_lvl_t role;
    logic [6:0] tgt_addr;
    logic strap_ok;

    srelc_sync #(.W(9)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({load_start_n, bus_clock_line_i, bus_data_line_i,
            bus_role_select_lvl, bus_address_strap_lvl}),
        .q(sync_q)
    );
    assign ls_s = sync_q[8];
    assign scl_s = sync_q[7];
    assign sda_s = sync_q[6];

    srelc_strap u_strap (
        .clk(clk),
        .resetn(resetn),
        .bus_role_select_lvl(sync_q[5:4]),
        .bus_address_strap_lvl(sync_q[3:0]),
        .role(role),
        .tgt_addr(tgt_addr),
        .valid(strap_ok)
    );

    logic is_ctl;
    logic is_tgt;
    logic srst;
    assign is_ctl = strap_ok && (role == LVL_FLOAT);
    assign is_tgt = strap_ok && (role == LVL_HIGH);
    assign srst = is_tgt && !ls_s;

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [6:0] dev_addr;
    logic reload;
    logic [2:0] status;
    logic [2:0] mask;
    logic [2:0] ev;
    logic [7:0] cfg_mem [LOAD_BYTES];
    srelc_state_t st;
    srelc_state_t st_q;
    logic [3:0] loaded;

    logic wr_go;
    logic [31:0] wmask;
    logic [31:0] wbits;
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign wbits = s_axi_wdata & wmask;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dev_addr <= `SRELC_DEV_RST;
            mask <= '0;
            reload <= 1'b0;
        end else if (srst) begin
            dev_addr <= `SRELC_DEV_RST;
            mask <= '0;
            reload <= 1'b0;
        end else begin
            reload <= 1'b0;
            if (wr_go && s_axi_awaddr == `SRELC_CTRL) begin
                reload <= wbits[`SRELC_CTRL_RELOAD];
                if (s_axi_wstrb[1])
                    dev_addr <= s_axi_wdata[`SRELC_CTRL_DEV_LSB +: 7];
            end
            if (wr_go && s_axi_awaddr == `SRELC_MASK && s_axi_wstrb[0])
                mask <= s_axi_wdata[2:0];
        end
    end

    // A new event wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status <= '0;
        end else if (srst) begin
            status <= '0;
        end else if (wr_go && s_axi_awaddr == `SRELC_STATUS) begin
            status <= (status & ~wbits[2:0]) | ev;
        end else begin
            status <= status | ev;
        end
    end

    // ---------------------------------------------------------------
    // Register slave
    // ---------------------------------------------------------------
    logic [31:0] rd_word;
    logic rd_hit;
    logic [7:0] cfg_off;
    // Full-width offset so that addresses past the table cannot alias onto it
    assign cfg_off = s_axi_araddr - `SRELC_CFG_BASE;

    always_comb begin
        rd_hit = 1'b1;
        rd_word = '0;
        case (s_axi_araddr)
            `SRELC_CTRL: rd_word[`SRELC_CTRL_DEV_LSB +: 7] = dev_addr;
            `SRELC_STATUS: rd_word[2:0] = status;
            `SRELC_MASK: rd_word[2:0] = mask;
            `SRELC_INFO: rd_word = {11'h0, st, loaded, done_n, role, tgt_addr};
            default: begin
                if (s_axi_araddr >= `SRELC_CFG_BASE && s_axi_araddr[1:0] == 2'h0
                    && cfg_off[7:2] < 6'(LOAD_BYTES))
                    rd_word[7:0] = cfg_mem[cfg_off[4:2]];
                else
                    rd_hit = 1'b0;
            end
        endcase
    end

    logic wr_hit;
    assign wr_hit = s_axi_awaddr == `SRELC_CTRL || s_axi_awaddr == `SRELC_STATUS
                    || s_axi_awaddr == `SRELC_MASK;

    // Unmapped addresses answer DECERR; INFO accepts and drops writes, the read-only table answers them with DECERR
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_hit || s_axi_awaddr == `SRELC_INFO) ? 2'h0 : 2'h3;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? 2'h0 : 2'h3;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // EEPROM read engine
    // ---------------------------------------------------------------
    logic [15:0] qcnt;
    logic [1:0] ph;
    logic [2:0] bit_cnt;
    logic [3:0] byte_idx;
    logic [7:0] shreg;
    logic nack;
    logic tick;
    logic reading;
    logic last;
    logic go;
    logic [2:0] rd_idx;

    // Holding the timer while the clock line is low lets a slow EEPROM stretch
    assign tick = (qcnt == '0) && !(ph == 2'd2 && !scl_s);
    assign reading = byte_idx >= 4'd3;
    assign last = byte_idx == 4'(2 + LOAD_BYTES);
    assign rd_idx = 3'(byte_idx - 4'd3);
    // Only the idle state starts a load, so a held-low start repeats it only after a reload returns the engine to idle
    assign go = is_ctl && !ls_s && st == ST_IDLE;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            qcnt <= '0;
        end else if (st == ST_IDLE || st == ST_OK || st == ST_FAIL || qcnt == '0) begin
            if (tick || st == ST_IDLE || st == ST_OK || st == ST_FAIL)
                qcnt <= 16'(QTR_CYC - 1);
        end else begin
            qcnt <= qcnt - 16'd1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= ST_IDLE;
            ph <= '0;
            bit_cnt <= '0;
            byte_idx <= '0;
            shreg <= '0;
            nack <= 1'b0;
            bus_clock_line_oe <= 1'b0;
            bus_data_line_oe <= 1'b0;
        end else if (srst || !is_ctl) begin
            st <= ST_IDLE;
            ph <= '0;
            bit_cnt <= '0;
            byte_idx <= '0;
            nack <= 1'b0;
            bus_clock_line_oe <= 1'b0;
            bus_data_line_oe <= 1'b0;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (go) begin
                        st <= ST_START;
                        ph <= '0;
                        byte_idx <= '0;
                        nack <= 1'b0;
                        shreg <= {dev_addr, 1'b0};
                    end
                end
                ST_START: begin
                    if (tick) begin
                        ph <= ph + 2'd1;
                        case (ph)
                            2'd0: bus_data_line_oe <= 1'b0;
                            2'd1: bus_clock_line_oe <= 1'b0;
                            2'd2: bus_data_line_oe <= 1'b1;
                            default: begin
                                bus_clock_line_oe <= 1'b1;
                                bit_cnt <= '0;
                                st <= ST_BIT;
                            end
                        endcase
                    end
                end
                ST_BIT: begin
                    if (tick) begin
                        ph <= ph + 2'd1;
                        case (ph)
                            2'd0: bus_data_line_oe <= !reading && !shreg[7];
                            2'd1: bus_clock_line_oe <= 1'b0;
                            2'd2: shreg <= {shreg[6:0], sda_s};
                            default: begin
                                bus_clock_line_oe <= 1'b1;
                                bit_cnt <= bit_cnt + 3'd1;
                                if (bit_cnt == 3'd7)
                                    st <= ST_ACK;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (tick) begin
                        ph <= ph + 2'd1;
                        case (ph)
                            2'd0: bus_data_line_oe <= reading && !last;
                            2'd1: bus_clock_line_oe <= 1'b0;
                            2'd2: nack <= nack | (!reading && sda_s);
                            default: begin
                                bus_clock_line_oe <= 1'b1;
                                bit_cnt <= '0;
                                byte_idx <= byte_idx + 4'd1;
                                if (nack || last) begin
                                    st <= ST_STOP;
                                end else if (byte_idx == 4'd1) begin
                                    st <= ST_START;
                                    shreg <= {dev_addr, 1'b1};
                                end else begin
                                    st <= ST_BIT;
                                    if (byte_idx == 4'd0)
                                        shreg <= `SRELC_EE_OFFSET;
                                end
                            end
                        endcase
                    end
                end
                ST_STOP: begin
                    if (tick) begin
                        ph <= ph + 2'd1;
                        case (ph)
                            2'd0: bus_data_line_oe <= 1'b1;
                            2'd1: bus_clock_line_oe <= 1'b0;
                            2'd2: bus_data_line_oe <= 1'b0;
                            default: st <= nack ? ST_FAIL : ST_OK;
                        endcase
                    end
                end
                ST_OK, ST_FAIL: begin
                    if (reload)
                        st <= ST_IDLE;
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            loaded <= '0;
            for (int i = 0; i < LOAD_BYTES; i++)
                cfg_mem[i] <= '0;
        end else if (srst) begin
            loaded <= '0;
            for (int i = 0; i < LOAD_BYTES; i++)
                cfg_mem[i] <= '0;
        end else if (st == ST_ACK && tick && ph == 2'd2 && reading) begin
            cfg_mem[rd_idx] <= shreg;
            loaded <= byte_idx - 4'd2;
        end else if (go) begin
            loaded <= '0;
        end
    end

    // ---------------------------------------------------------------
    // Events, done and interrupt pins
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            st_q <= ST_IDLE;
        else
            st_q <= st;
    end

    assign ev[`SRELC_EV_OK] = st == ST_OK && st_q != ST_OK;
    assign ev[`SRELC_EV_FAIL] = st == ST_FAIL && st_q != ST_FAIL;
    assign ev[`SRELC_EV_START] = st == ST_START && st_q == ST_IDLE;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done_n <= 1'b1;
            int_n_oe <= 1'b0;
        end else begin
            if (is_tgt)
                done_n <= ls_s;
            else
                done_n <= !(is_ctl && st == ST_OK);
            int_n_oe <= |(status & mask);
        end
    end

    // Pins are open-drain: the driven value is always low, only enables move
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_n_o <= 1'b0;
            bus_clock_line_o <= 1'b0;
            bus_data_line_o <= 1'b0;
        end else begin
            int_n_o <= 1'b0;
            bus_clock_line_o <= 1'b0;
            bus_data_line_o <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_addr_frozen: assert property (strap_ok |=> $stable(tgt_addr))
        else $error("target address changed after capture");
    a_role_idle: assert property (strap_ok && !is_ctl |=> st == ST_IDLE)
        else $error("engine active outside controller role");
    a_load_start: assert property (go |=> st == ST_START ##0 bus_data_line_oe == 1'b0)
        else $error("load did not start");
    a_no_restart: assert property (st == ST_OK && !reload && !srst |=> st == ST_OK)
        else $error("finished load restarted");
    a_tgt_reset: assert property (srst |=> status == '0 && st == ST_IDLE && mask == '0)
        else $error("target reset did not clear state");
    a_done_good: assert property ($fell(done_n) && !is_tgt |-> $past(st == ST_OK))
        else $error("done low without good load");
    a_done_mirror: assert property (is_tgt && $past(is_tgt) |-> done_n == $past(ls_s))
        else $error("done does not follow load start");
    a_int_follow: assert property (|(status & mask) |=> int_n_oe)
        else $error("interrupt not raised");
    a_int_quiet: assert property (mask == '0 ##1 mask == '0 |-> !int_n_oe)
        else $error("masked event raised interrupt");
    a_od_pins: assert property (!int_n_o && !bus_data_line_o && !bus_clock_line_o)
        else $error("open-drain pin driven high");
    a_fail_done: assert property (st == ST_FAIL |=> done_n)
        else $error("failed load shows done");
    a_stretch: assert property (ph == 2'd2 && !scl_s && st != ST_IDLE |=> $stable(ph))
        else $error("clock stretch ignored");

    c_load_ok: cover property (st == ST_STOP ##1 st == ST_OK);
    c_load_fail: cover property (st == ST_STOP ##1 st == ST_FAIL);
    c_tgt_hold: cover property (srst ##1 !srst);
    c_irq: cover property (!int_n_oe ##1 int_n_oe);

endmodule : srelc_top

// File: sim/srelc_eeprom_model.sv
// Behavioural EEPROM on the two-wire bus with optional clock stretching
`timescale 1ns/10ps

module srelc_eeprom_model (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic nack,
    input wire logic slow,
    output logic sda_pull,
    output logic scl_pull
);
    logic [3:0] bc = 4'h0;
    logic [7:0] sh = 8'h00;
    logic [2:0] ptr = 3'h0;
    logic rd = 1'b0, adr = 1'b0;
    wire logic [7:0] dat = 8'h96 + {5'h0, ptr};
    initial sda_pull = 1'b0;
    initial scl_pull = 1'b0;
    always @(negedge sda) if (scl) begin
        bc = 4'h0;
        adr = 1'b1;
        rd = 1'b0;
    end
    always @(posedge sda) if (scl) ptr = 3'h0;
    always @(posedge scl) begin
        if (bc < 4'h8) begin
            sh = {sh[6:0], sda};
            bc = bc + 4'h1;
        end else begin
            bc = 4'h0;
            if (rd) ptr = ptr + 3'h1;
            if (rd && sda) rd = 1'b0;
            if (adr) rd = sh[0];
            adr = 1'b0;
        end
    end
    // Data moves only while the clock is low; a released line floats high
    always @(negedge scl) begin
        if (bc == 4'h8) sda_pull = !rd && !nack;
        else if (rd) sda_pull = !dat[3'h7 - bc[2:0]];
        else sda_pull = 1'b0;
    end
    always @(negedge scl) if (slow) begin
        scl_pull = 1'b1;
        repeat (20) @(posedge clk);
        scl_pull = 1'b0;
    end
endmodule : srelc_eeprom_model

// File: sim/tb.sv
// Self-checking bench for straps, EEPROM load, interrupt and target hold
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
    $display("BAD %0t got %h want %h", $time, (a), (e)); end end
`define WT(c) for (int n = 0; n < 9000 && !(c); n++) @(negedge clk); if (!(c)) die;

module tb;
    logic clk = 1'b0, resetn = 1'b0, load_start_n = 1'b1, nack = 1'b0, slow = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, od_bad = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf, bus_address_strap_lvl = 4'h0;
    logic [1:0] bus_role_select_lvl = 2'h2, s_axi_bresp, s_axi_rresp, r;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, done_n, int_n_o, int_n_oe;
    logic bus_clock_line_i, bus_clock_line_o, bus_clock_line_oe, scl_pull;
    logic bus_data_line_i, bus_data_line_o, bus_data_line_oe, sda_pull;
    int err_total = 0, compares = 0;

    srelc_top #(.QTR_CYC(3), .LOAD_BYTES(8)) i_dut (.*);
    srelc_eeprom_model i_eeprom (.clk(clk), .scl(bus_clock_line_i), .sda(bus_data_line_i),
        .nack(nack), .slow(slow), .sda_pull(sda_pull), .scl_pull(scl_pull));

    always #2 clk = ~clk;
    // Pull-ups on both wires: whoever pulls wins
    assign bus_clock_line_i = !(bus_clock_line_oe || scl_pull);
    assign bus_data_line_i = !(bus_data_line_oe || sda_pull);
    always @(posedge clk) if (resetn && {bus_clock_line_o, bus_data_line_o, int_n_o} !== 3'h0)
        od_bad <= 1'b1;

    // ---------------------------------------------------------------
    // Bus tasks
    // ---------------------------------------------------------------
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    task automatic die;
        err_total++;
        close_out;
    endtask : die
    task automatic hard(input logic [1:0] role);
        @(posedge clk);
        resetn <= 1'b0;
        bus_role_select_lvl <= role;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (12) @(posedge clk);
    endtask : hard
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ok, a_t, w_t;
        ok = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (int n = 0; n < 50 && !ok; n++) begin
            @(negedge clk);
            {ok, rs, a_t, w_t} = {s_axi_bvalid, s_axi_bresp, s_axi_awready, s_axi_wready};
            @(posedge clk);
            if (a_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            if (ok) s_axi_bready <= 1'b0;
        end
        if (!ok) die;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ok, a_t;
        ok = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (int n = 0; n < 50 && !ok; n++) begin
            @(negedge clk);
            {ok, v, rs, a_t} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp, s_axi_arready};
            @(posedge clk);
            if (a_t) s_axi_arvalid <= 1'b0;
            if (ok) s_axi_rready <= 1'b0;
        end
        if (!ok) die;
    endtask : rd

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        for (int i = 0; i < 16; i++) begin
            bus_address_strap_lvl <= i[3:0];
            hard(2'h2);
            bus_address_strap_lvl <= ~i[3:0];
            rd(8'h0c, d, r);
            `CHK(d[9:0], {3'h6, 3'h3, i[3:0]})
        end
        `CHK(done_n, 1'b1)
        rd(8'h40, d, r);
        `CHK(r, 2'h3)
        wr(8'h14, 32'h1, r);
        `CHK(r, 2'h3)
        $display("end straps");
        slow <= 1'b1;
        wr(8'h08, 32'h7, r);
        load_start_n <= 1'b0;
        `WT(done_n === 1'b0)
        rd(8'h04, d, r);
        `CHK(d[2:0], 3'h5)
        `CHK(int_n_oe, 1'b1)
        for (int i = 0; i < 8; i++) begin
            rd(8'h20 + 8'(4 * i), d, r);
            `CHK(d[7:0], 8'h96 + 8'(i))
        end
        wr(8'h08, 32'h2, r);
        rd(8'h04, d, r);
        `CHK(int_n_oe, 1'b0)
        wr(8'h04, 32'h7, r);
        repeat (200) @(posedge clk);
        rd(8'h04, d, r);
        `CHK({done_n, d[2:0]}, 4'h0)
        $display("end good load");
        {nack, slow} <= 2'h2;
        wr(8'h00, 32'h5001, r);
        `WT(int_n_oe === 1'b1)
        rd(8'h04, d, r);
        `CHK({done_n, d[2:0]}, 4'he)
        $display("end failed load");
        load_start_n <= 1'b1;
        hard(2'h3);
        wr(8'h08, 32'h5, r);
        rd(8'h08, d, r);
        `CHK(d[2:0], 3'h5)
        load_start_n <= 1'b0;
        repeat (6) @(negedge clk);
        `CHK(done_n, 1'b0)
        rd(8'h08, d, r);
        `CHK({bus_clock_line_oe, bus_data_line_oe, d[2:0]}, 5'h0)
        load_start_n <= 1'b1;
        repeat (6) @(negedge clk);
        `CHK(done_n, 1'b1)
        `CHK(od_bad, 1'b0)
        $display("end target role");
        hard(2'h1);
        load_start_n <= 1'b0;
        repeat (100) @(negedge clk);
        rd(8'h0c, d, r);
        `CHK({done_n, d[20:14], d[8:7]}, {1'b1, 7'h01, 2'h1})
        `CHK({bus_clock_line_oe, bus_data_line_oe, d[9]}, 3'h1)
        $display("end reserved role");
        close_out;
    end
endmodule : tb
